/* File: rtl/pse_pkg.sv */
// Shared constants and types for the port command register bank
package pse_pkg;
    localparam int NUM_PORTS = 4;
    localparam logic [7:0] ADDR_RESTART = 8'h18;
    localparam logic [7:0] ADDR_POWER = 8'h19;
    localparam logic [7:0] ADDR_RESET = 8'h1A;
    localparam logic [7:0] ADDR_LEGACY = 8'h20;
    localparam logic [7:0] ADDR_SECOND_CLASS = 8'h21;
    localparam logic [7:0] LEGACY_RESET = 8'h00;
    localparam logic [7:0] SECOND_CLASS_RESET = 8'h00;
    // Field positions
    localparam int HI_NIBBLE = 4;
    localparam int BIT_CLEAR_ALL = 7;
    localparam int BIT_RELEASE_PIN = 6;
    localparam int BIT_RESET_ALL = 4;
    localparam int FIELD_W = 2;
    localparam logic [1:0] FIELD_OFF = 2'h0;
    localparam logic [1:0] FIELD_RESERVED_SECOND = 2'h2;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [3:0] PORTS_NONE = 4'h0;
    // Host spacing after restart/off/reset before enable write
    localparam real HOST_GAP_MS = 1.2;
    localparam int CLOCK_MHZ = 100;
    localparam int HOST_GAP_CYCLES = int'(HOST_GAP_MS * 1000.0) * CLOCK_MHZ;

    typedef enum logic [1:0] {
        PSE_MODE_OFF,
        PSE_MODE_MANUAL,
        PSE_MODE_SEMI_AUTO,
        PSE_MODE_AUTO
    } pse_mode_t;

    typedef struct packed {
        logic [3:0] detect_cycle;
        logic [3:0] class_cycle;
        logic [3:0] set_detect_en;
        logic [3:0] set_class_en;
        logic [3:0] power_on;
        logic [3:0] power_off;
        logic [3:0] port_reset;
        logic [3:0] power_change_set;
        logic [3:0] second_class_arm;
    } pse_port_cmd_t;

    typedef struct packed {
        logic clear_all_interrupts;
        logic release_alert_pin;
        logic reset_all;
    } pse_global_cmd_t;
endpackage : pse_pkg

/* File: rtl/pse_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pse_pin_sync (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_en,
    input wire logic i_pin,
    output logic o_level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            o_level <= 1'b0;
        end else if (i_clock_en) begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                o_level <= stage3;
            end
        end
    end
endmodule : pse_pin_sync

/* File: rtl/pse_cmd_regs.sv */
// Command and configuration register bank for a four-port power controller
`timescale 1ns/1ps
module pse_cmd_regs (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_en,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] i_rd_addr,
    input wire pse_pkg::pse_mode_t i_mode,
    input wire logic [3:0] i_port_powered,
    input wire logic [3:0] i_cooldown,
    input wire logic [3:0] i_legacy_found,
    input wire logic [3:0] i_class_enable_set,
    input wire logic i_fast_port_off_pin,
    output pse_pkg::pse_port_cmd_t o_port_cmd,
    output pse_pkg::pse_global_cmd_t o_global_cmd,
    output logic [3:0] o_clear_resistance,
    output logic [3:0] o_cancel_cooldown,
    output logic [3:0] o_repeat_allowed,
    output logic [3:0] o_hold_auto_power,
    output logic [7:0] o_legacy_detect_mode,
    output logic [7:0] o_second_class_event_ctrl,
    output logic [7:0] o_rd_data
);
    localparam int N = pse_pkg::NUM_PORTS;
    localparam int HI = pse_pkg::HI_NIBBLE;

    // Port count is fixed by the register layout
    if (N != 4) begin : g_bad_port_count
        $error("pse_cmd_regs serves exactly four ports");
    end

    // Per-port 2-bit field select
    function automatic logic [1:0] field_of(input logic [7:0] regv, input int port);
        field_of = regv[port*pse_pkg::FIELD_W +: pse_pkg::FIELD_W];
    endfunction : field_of

    logic shutdown;
    logic [7:0] legacy_detect_mode;
    logic [7:0] second_class_event_ctrl;
    logic [3:0] pend_detect;
    logic [3:0] pend_class;
    logic [3:0] hold_auto_power;

    pse_pin_sync u_shutdown_sync (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_clock_en(i_clock_en),
        .i_pin(i_fast_port_off_pin),
        .o_level(shutdown)
    );

    // Address decode
    wire wr_restart = i_wr_valid && (i_wr_addr == pse_pkg::ADDR_RESTART);
    wire wr_power = i_wr_valid && (i_wr_addr == pse_pkg::ADDR_POWER);
    wire wr_reset = i_wr_valid && (i_wr_addr == pse_pkg::ADDR_RESET);
    wire wr_legacy = i_wr_valid && (i_wr_addr == pse_pkg::ADDR_LEGACY);
    wire wr_second = i_wr_valid && (i_wr_addr == pse_pkg::ADDR_SECOND_CLASS);

    wire is_manual = (i_mode == pse_pkg::PSE_MODE_MANUAL);
    wire is_auto = (i_mode == pse_pkg::PSE_MODE_SEMI_AUTO) ||
                   (i_mode == pse_pkg::PSE_MODE_AUTO);
    wire is_off_mode = (i_mode == pse_pkg::PSE_MODE_OFF);

    wire [3:0] req_detect = wr_restart ? i_wr_data[HI-1:0] : pse_pkg::PORTS_NONE;
    wire [3:0] req_class = wr_restart ? i_wr_data[2*HI-1:HI] : pse_pkg::PORTS_NONE;
    wire [3:0] req_port_reset = wr_reset ? i_wr_data[HI-1:0] : pse_pkg::PORTS_NONE;
    wire req_clear_all = wr_reset && i_wr_data[pse_pkg::BIT_CLEAR_ALL];
    wire req_release = wr_reset && i_wr_data[pse_pkg::BIT_RELEASE_PIN];
    wire req_reset_all = wr_reset && i_wr_data[pse_pkg::BIT_RESET_ALL];

    // Power forcing gated by off mode and the pin
    wire power_allowed = !is_off_mode && !shutdown;
    wire [3:0] raw_on = wr_power ? i_wr_data[HI-1:0] : pse_pkg::PORTS_NONE;
    wire [3:0] raw_off = wr_power ? i_wr_data[2*HI-1:HI] : pse_pkg::PORTS_NONE;
    wire [3:0] eff_off = power_allowed ? raw_off : pse_pkg::PORTS_NONE;
    wire [3:0] on_no_conflict = raw_on & ~raw_off;
    // Cool-down blocks power-on outside manual mode
    wire [3:0] on_cool_ok = is_manual ? on_no_conflict : (on_no_conflict & ~i_cooldown);
    wire [3:0] eff_on = power_allowed ? on_cool_ok : pse_pkg::PORTS_NONE;

    // Deferral while cooling; port reset lifts the lockout
    wire [3:0] cool_eff = i_cooldown & ~req_port_reset;
    wire [3:0] all_detect = req_detect | pend_detect;
    wire [3:0] all_class = req_class | pend_class;
    wire [3:0] go_detect = all_detect & ~cool_eff;
    wire [3:0] go_class = all_class & ~cool_eff;
    wire [3:0] next_pend_detect = all_detect & cool_eff;
    wire [3:0] next_pend_class = all_class & cool_eff;

    // Manual runs a cycle, auto modes set enables
    wire [3:0] run_detect = is_manual ? go_detect : pse_pkg::PORTS_NONE;
    wire [3:0] run_class = is_manual ? go_class : pse_pkg::PORTS_NONE;
    wire [3:0] set_det_en = is_auto ? go_detect : pse_pkg::PORTS_NONE;
    wire [3:0] set_cls_en = is_auto ? go_class : pse_pkg::PORTS_NONE;

    // Change flags only for a port that was powered
    wire [3:0] off_any = eff_off | req_port_reset;
    wire [3:0] change_set = off_any & i_port_powered;

    // Second class arming per port field and mode
    logic [3:0] field_armed;
    always_comb begin
        for (int p = 0; p < N; p++) begin
            field_armed[p] = (field_of(second_class_event_ctrl, p) != pse_pkg::FIELD_OFF) &&
                (field_of(second_class_event_ctrl, p) != pse_pkg::FIELD_RESERVED_SECOND);
        end
    end
    wire [3:0] class_trigger = is_manual ? (run_class | i_class_enable_set) :
                               is_auto ? (eff_on | i_class_enable_set) : pse_pkg::PORTS_NONE;
    wire [3:0] arm_second = class_trigger & field_armed;

    // Legacy port held off until host power-on, power-off or port reset
    wire [3:0] next_hold = is_auto ? ((hold_auto_power | i_legacy_found) & ~eff_on & ~off_any)
                                   : pse_pkg::PORTS_NONE;

    // Repetition allowed in auto modes while unpowered, not cooling and not held for legacy
    wire [3:0] next_repeat = is_auto ? (~i_port_powered & ~i_cooldown & ~hold_auto_power)
                                     : pse_pkg::PORTS_NONE;

    // Read mux; command registers are write-only
    wire [7:0] next_rd_data =
        (i_rd_addr == pse_pkg::ADDR_LEGACY) ? legacy_detect_mode :
        (i_rd_addr == pse_pkg::ADDR_SECOND_CLASS) ? second_class_event_ctrl :
        pse_pkg::READ_ZERO;

    wire soft_reset = i_srst || (i_clock_en && req_reset_all);

    // Legacy and second class field storage, zero at reset
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            legacy_detect_mode <= pse_pkg::LEGACY_RESET;
            second_class_event_ctrl <= pse_pkg::SECOND_CLASS_RESET;
        end else if (i_clock_en) begin
            if (wr_legacy) begin
                legacy_detect_mode <= i_wr_data;
            end
            if (wr_second) begin
                second_class_event_ctrl <= i_wr_data;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            pend_detect <= pse_pkg::PORTS_NONE;
            pend_class <= pse_pkg::PORTS_NONE;
            hold_auto_power <= pse_pkg::PORTS_NONE;
        end else if (i_clock_en) begin
            pend_detect <= next_pend_detect;
            pend_class <= next_pend_class;
            hold_auto_power <= next_hold;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_port_cmd <= '0;
            o_clear_resistance <= pse_pkg::PORTS_NONE;
            o_cancel_cooldown <= pse_pkg::PORTS_NONE;
        end else if (i_clock_en) begin
            o_port_cmd.detect_cycle <= run_detect;
            o_port_cmd.class_cycle <= run_class;
            o_port_cmd.set_detect_en <= set_det_en;
            o_port_cmd.set_class_en <= set_cls_en;
            o_port_cmd.power_on <= eff_on & ~req_port_reset;
            o_port_cmd.power_off <= eff_off;
            o_clear_resistance <= eff_off;
            // Port reset in any mode, lifts cool-down
            o_port_cmd.port_reset <= req_port_reset;
            o_cancel_cooldown <= req_port_reset;
            o_port_cmd.power_change_set <= change_set;
            o_port_cmd.second_class_arm <= arm_second;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_global_cmd <= '0;
        end else if (i_clock_en) begin
            o_global_cmd.clear_all_interrupts <= req_clear_all;
            o_global_cmd.release_alert_pin <= req_release;
            o_global_cmd.reset_all <= req_reset_all;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_repeat_allowed <= pse_pkg::PORTS_NONE;
            o_hold_auto_power <= pse_pkg::PORTS_NONE;
            o_legacy_detect_mode <= pse_pkg::LEGACY_RESET;
            o_second_class_event_ctrl <= pse_pkg::SECOND_CLASS_RESET;
            o_rd_data <= pse_pkg::READ_ZERO;
        end else if (i_clock_en) begin
            o_repeat_allowed <= next_repeat;
            o_hold_auto_power <= next_hold;
            o_legacy_detect_mode <= legacy_detect_mode;
            o_second_class_event_ctrl <= second_class_event_ctrl;
            o_rd_data <= next_rd_data;
        end
    end
endmodule : pse_cmd_regs

/* File: sim/pse_host_model.sv */
// Host side model issuing single-byte register writes
`timescale 1ns/1ps
module pse_host_model (
    input wire logic i_clock,
    output logic o_wr_valid,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data
);
    initial begin
        o_wr_valid = 1'b0;
        o_wr_addr = 8'hFF;
        o_wr_data = 8'h00;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock) #1 o_wr_valid = 1'b1;
        o_wr_addr = a;
        o_wr_data = d;
        @(posedge i_clock) #1 o_wr_valid = 1'b0;
        o_wr_addr = ~a;
        o_wr_data = ~d;
    endtask : write
endmodule : pse_host_model

/* File: sim/pse_cmd_regs_properties.sv */
// Port-level checks of the command register bank
`timescale 1ns/1ps
module pse_cmd_regs_checker (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_en,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input pse_pkg::pse_mode_t i_mode,
    input wire logic [3:0] i_cooldown,
    input wire logic i_fast_port_off_pin,
    input pse_pkg::pse_port_cmd_t o_port_cmd,
    input pse_pkg::pse_global_cmd_t o_global_cmd,
    input wire logic [3:0] o_clear_resistance,
    input wire logic [3:0] o_cancel_cooldown
);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_srst);
    logic [7:0] wd_q;
    logic [2:0] low_cnt;
    wire tk = i_clock_en && i_wr_valid;
    wire w18 = tk && i_wr_addr == 8'h18;
    wire w19 = tk && i_wr_addr == 8'h19;
    wire w1a = tk && i_wr_addr == 8'h1A;
    wire man = i_mode == pse_pkg::PSE_MODE_MANUAL;
    wire quiet = low_cnt == 3'h7;
    always_ff @(posedge i_clock) begin
        wd_q <= i_wr_data;
        low_cnt <= (i_srst || i_fast_port_off_pin) ? 3'h0 : low_cnt + {2'h0, !quiet};
    end
    restart_manual_a: assert property (
        w18 && man && i_cooldown == 4'h0 |=> (o_port_cmd.detect_cycle & wd_q[3:0]) == wd_q[3:0]
        && (o_port_cmd.class_cycle & wd_q[7:4]) == wd_q[7:4]) else $error("restart lost");
    restart_defer_a: assert property (
        w18 && man && i_cooldown[0] && $stable(i_cooldown) |=> !o_port_cmd.detect_cycle[0])
        else $error("restart not deferred");
    off_wins_a: assert property (
        w19 |=> (o_port_cmd.power_on & wd_q[7:4]) == 4'h0) else $error("on beat off");
    power_off_a: assert property (
        w19 && i_mode != pse_pkg::PSE_MODE_OFF && quiet |=> o_port_cmd.power_off == wd_q[7:4]
        && o_clear_resistance == wd_q[7:4]) else $error("power off missing");
    off_mode_a: assert property (
        w19 && i_mode == pse_pkg::PSE_MODE_OFF |=> o_port_cmd.power_on == 4'h0
        && o_port_cmd.power_off == 4'h0) else $error("power cmd in off mode");
    cool_on_a: assert property (
        w19 && i_mode >= pse_pkg::PSE_MODE_SEMI_AUTO && i_cooldown[2]
        |=> !o_port_cmd.power_on[2]) else $error("power on during cool-down");
    port_reset_a: assert property (
        w1a |=> o_port_cmd.port_reset == wd_q[3:0] && o_cancel_cooldown == wd_q[3:0])
        else $error("port reset mismatch");
    global_cmd_a: assert property (
        w1a |=> o_global_cmd == {wd_q[7], wd_q[6], wd_q[4]}) else $error("global cmd mismatch");
    cover property (w18 && man);
    cover property (w19 && quiet);
    cover property (w1a);
endmodule : pse_cmd_regs_checker
bind pse_cmd_regs pse_cmd_regs_checker chk_u (.i_clock(i_clock), .i_srst(i_srst),
    .i_clock_en(i_clock_en), .i_wr_valid(i_wr_valid), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .i_mode(i_mode), .i_cooldown(i_cooldown),
    .i_fast_port_off_pin(i_fast_port_off_pin), .o_port_cmd(o_port_cmd),
    .o_global_cmd(o_global_cmd), .o_clear_resistance(o_clear_resistance),
    .o_cancel_cooldown(o_cancel_cooldown));

/* File: sim/test_pse_cmd_regs.sv */
// Self-checking bench for the command register bank
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_pse_cmd_regs;
    logic i_clock = 1'b0;
    logic srst = 1'b1;
    pse_pkg::pse_mode_t mode = pse_pkg::PSE_MODE_MANUAL;
    logic [3:0] pwr = 4'h0;
    logic [3:0] cool = 4'h0;
    logic pin = 1'b0;
    logic [7:0] ra = 8'h00;
    logic wv;
    logic [7:0] wa;
    logic [7:0] wd;
    pse_pkg::pse_port_cmd_t pc;
    pse_pkg::pse_global_cmd_t gc;
    logic [3:0] clr;
    logic [3:0] cnc;
    logic [7:0] rdat;
    logic [3:0] lf = 4'h0;
    logic [3:0] ces = 4'h0;
    logic [3:0] rep;
    logic [3:0] hold;
    logic [7:0] lgm;
    logic [7:0] scm;
    int n_errors = 0;
    int comparisons = 0;
    initial begin
        forever #5 i_clock = ~i_clock;
    end
    pse_host_model host_u (.i_clock(i_clock), .o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd));
    pse_cmd_regs dut_u (.i_clock(i_clock), .i_srst(srst), .i_clock_en(1'b1), .i_wr_valid(wv),
        .i_wr_addr(wa), .i_wr_data(wd), .i_rd_addr(ra), .i_mode(mode), .i_port_powered(pwr),
        .i_cooldown(cool), .i_legacy_found(lf), .i_class_enable_set(ces),
        .i_fast_port_off_pin(pin), .o_port_cmd(pc), .o_global_cmd(gc),
        .o_clear_resistance(clr), .o_cancel_cooldown(cnc), .o_repeat_allowed(rep),
        .o_hold_auto_power(hold), .o_legacy_detect_mode(lgm), .o_second_class_event_ctrl(scm),
        .o_rd_data(rdat));
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clock) #1 ra = a;
        repeat (2) @(posedge i_clock);
        #1 `CHK(rdat, e)
    endtask : rd
    task automatic final_report;
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        #100000 n_errors++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge i_clock);
        #1 srst = 1'b0;
        rd(8'h20, 8'h00);
        host_u.write(8'h18, 8'hA5);
        `CHK({pc.class_cycle, pc.detect_cycle}, 8'hA5)
        @(posedge i_clock) #1 `CHK(pc.detect_cycle, 4'h0)
        mode = pse_pkg::PSE_MODE_AUTO;
        host_u.write(8'h18, 8'h12);
        `CHK({pc.set_class_en, pc.set_detect_en, pc.detect_cycle}, 12'h120)
        mode = pse_pkg::PSE_MODE_MANUAL;
        cool = 4'h1;
        host_u.write(8'h18, 8'h01);
        `CHK(pc.detect_cycle, 4'h0)
        cool = 4'h0;
        @(posedge i_clock) #1 `CHK(pc.detect_cycle, 4'h1)
        pwr = 4'h1;
        host_u.write(8'h19, 8'h11);
        `CHK({pc.power_on, pc.power_off, pc.power_change_set, clr}, 16'h0111)
        mode = pse_pkg::PSE_MODE_OFF;
        host_u.write(8'h19, 8'h2F);
        `CHK({pc.power_on, pc.power_off}, 8'h00)
        mode = pse_pkg::PSE_MODE_MANUAL;
        pin = 1'b1;
        repeat (5) @(posedge i_clock);
        host_u.write(8'h19, 8'h0F);
        `CHK(pc.power_on, 4'h0)
        pin = 1'b0;
        repeat (5) @(posedge i_clock);
        cool = 4'h4;
        host_u.write(8'h19, 8'h04);
        `CHK(pc.power_on, 4'h4)
        mode = pse_pkg::PSE_MODE_SEMI_AUTO;
        host_u.write(8'h19, 8'h04);
        `CHK(pc.power_on, 4'h0)
        cool = 4'h0;
        lf = 4'h4;
        @(posedge i_clock) #1 lf = 4'h0;
        `CHK(hold, 4'h4)
        @(posedge i_clock) #1 `CHK(rep, 4'hA)
        host_u.write(8'h19, 8'h04);
        `CHK({pc.power_on, hold}, 8'h40)
        host_u.write(8'h1A, 8'hC9);
        `CHK({gc, pc.port_reset, cnc, clr, pc.power_change_set}, 19'h69901)
        host_u.write(8'h1A, 8'h40);
        `CHK(gc, 3'h2)
        host_u.write(8'h1A, 8'h00);
        `CHK({pc, gc}, 39'h0)
        host_u.write(8'h20, 8'h9C);
        rd(8'h20, 8'h9C);
        `CHK(lgm, 8'h9C)
        host_u.write(8'h21, 8'h55);
        rd(8'h21, 8'h55);
        `CHK(scm, 8'h55)
        host_u.write(8'h19, 8'h02);
        `CHK({pc.power_on, pc.second_class_arm}, 8'h22)
        ces = 4'h8;
        @(posedge i_clock) #1 ces = 4'h0;
        `CHK(pc.second_class_arm, 4'h8)
        mode = pse_pkg::PSE_MODE_MANUAL;
        host_u.write(8'h18, 8'h30);
        `CHK({pc.class_cycle, pc.second_class_arm}, 8'h33)
        host_u.write(8'h1A, 8'h10);
        `CHK(gc, 3'h1)
        rd(8'h20, 8'h00);
        rd(8'h18, 8'h00);
        final_report();
    end
endmodule : test_pse_cmd_regs
